// *** rtl/nv_pkg.sv ***
// package for the byte-wide nonvolatile data store controller
// assumes one system clock and a synchronous active-low reset
package nv_pkg;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [7:0] CMD_OFFSET      = 8'h40;  // bank 1, indirect only
  localparam logic [7:0] CMD_BANK        = 8'h01;
  localparam logic [7:0] LOC_OFFSET      = 8'h00;  // bank 0, direct
  localparam logic [7:0] BYTE_OFFSET     = 8'h01;  // bank 0, direct
  localparam logic [7:0] DIRECT_BANK     = 8'h00;
  localparam int         FETCH_START_BIT = 0;
  localparam int         FETCH_PERMIT_BIT = 1;
  localparam int         PROG_START_BIT  = 2;
  localparam int         PROG_PERMIT_BIT = 3;
  localparam logic [7:0] BYTE_RESET      = 8'h00;
  localparam logic [7:0] LOC_RESET       = 8'h00;
  localparam logic [3:0] CMD_RESET       = 4'h0;
  localparam int         FETCH_CYCLES    = 2;
  localparam int         PROG_CYCLES     = 16;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_fetch = 2'b01,
    st_prog  = 2'b10
  } nv_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

endpackage

// *** rtl/nv_byte_access_ctrl.sv ***
// controller for a small byte-wide nonvolatile data array behind three sfrs
// assumes cpu issues single-cycle sfr reads/writes, indirect decode done upstream
//
// Overview of operation
// - location register keeps 6 or 5 address bits
// - command register at 40h in bank 1
// - program permit low blocks starting a program; a program already running still completes
// - program start only acts if permit already set
// - hardware clears program start when done
// - fetch permit low blocks starting a fetch; a fetch already running still completes
// - fetch start only acts if permit set
// - fetch start cleared, byte register then valid
// - byte register holds until next operation
// - program stores byte register at location
// - program timer asynchronous, completion time varies
// - all command bits clear at reset
// - program end raises completion pending flag
// - pending flag cleared when interrupt serviced, unless a program ends in the same cycle
// - command upper four bits read zero
// - byte register eight bits, resets zero
// - location and byte registers in bank 0
// - array is 32 or 64 bytes
`timescale 1ns/1ns
module nv_byte_access_ctrl #(
  parameter int ADDR_BITS  = 6,
  parameter int PROG_TICKS = nv_pkg::PROG_CYCLES
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire nv_pkg::sfr_req_t req,
  input  wire logic             prog_tick,
  input  wire logic             irq_serviced,
  output logic [7:0]            rdata,
  output logic                  nv_done_pending,
  output logic                  prog_busy
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (ADDR_BITS != 5 && ADDR_BITS != 6) begin : g_bad_addr
    $error("ADDR_BITS must be 5 or 6");
  end
  if (PROG_TICKS < 1 || PROG_TICKS > 255) begin : g_bad_ticks
    $error("PROG_TICKS out of range");
  end

  localparam int DEPTH = 1 << ADDR_BITS;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    nv_pkg::nv_state_t    st;
    logic [3:0]           cmd;
    logic [ADDR_BITS-1:0] loc;
    logic [7:0]           data;
    logic [7:0]           cnt;
    logic                 pend;
    logic [7:0]           rdata;
    logic                 tick_s1;
    logic                 tick_s2;
    logic                 tick_s3;
  } ctrl_t;

  ctrl_t s;
  ctrl_t next_s;
  logic [7:0] mem [DEPTH];
  logic       mem_we;

  logic sel_cmd;
  logic sel_loc;
  logic sel_byte;
  logic tick_edge;

  // ****************************************
  // decode
  // ****************************************
  assign sel_cmd  = req.bank == nv_pkg::CMD_BANK && req.addr == nv_pkg::CMD_OFFSET;
  assign sel_loc  = req.bank == nv_pkg::DIRECT_BANK && req.addr == nv_pkg::LOC_OFFSET;
  assign sel_byte = req.bank == nv_pkg::DIRECT_BANK && req.addr == nv_pkg::BYTE_OFFSET;
  // program timer runs off its own oscillator, so ticks are synchronised first
  assign tick_edge = s.tick_s2 & ~s.tick_s3;

  always_comb begin
    logic [3:0] w;
    w = req.wdata[3:0];
    next_s = s;
    mem_we = 1'b0;
    next_s.tick_s1 = prog_tick;
    next_s.tick_s2 = s.tick_s1;
    next_s.tick_s3 = s.tick_s2;

    // read path
    if (sel_cmd) begin
      next_s.rdata = {4'h0, s.cmd};
    end else if (sel_loc) begin
      next_s.rdata = 8'(s.loc);
    end else if (sel_byte) begin
      next_s.rdata = s.data;
    end else begin
      next_s.rdata = 8'h00;
    end

    if (irq_serviced) begin
      next_s.pend = 1'b0;
    end

    unique case (s.st)
      nv_pkg::st_idle: begin
        if (req.wr && sel_loc) begin
          next_s.loc = req.wdata[ADDR_BITS-1:0];
        end
        if (req.wr && sel_byte) begin
          next_s.data = req.wdata;
        end
        if (req.wr && sel_cmd) begin
          next_s.cmd[nv_pkg::PROG_PERMIT_BIT]  = w[nv_pkg::PROG_PERMIT_BIT];
          next_s.cmd[nv_pkg::FETCH_PERMIT_BIT] = w[nv_pkg::FETCH_PERMIT_BIT];
          next_s.cmd[nv_pkg::PROG_START_BIT]   = 1'b0;
          next_s.cmd[nv_pkg::FETCH_START_BIT]  = 1'b0;
          // permit must already be set; same-write permit does not count
          if (w[nv_pkg::PROG_START_BIT] && s.cmd[nv_pkg::PROG_PERMIT_BIT]) begin
            next_s.cmd[nv_pkg::PROG_START_BIT] = 1'b1;
            next_s.st  = nv_pkg::st_prog;
            next_s.cnt = 8'(PROG_TICKS);
          end else if (w[nv_pkg::FETCH_START_BIT]
                       && s.cmd[nv_pkg::FETCH_PERMIT_BIT]) begin
            next_s.cmd[nv_pkg::FETCH_START_BIT] = 1'b1;
            next_s.st  = nv_pkg::st_fetch;
            next_s.cnt = 8'(nv_pkg::FETCH_CYCLES);
          end
        end
      end
      nv_pkg::st_fetch: begin
        // location and byte register writes during a cycle are dropped to keep address and data stable; command permit bits still update
        if (req.wr && sel_cmd) begin
          next_s.cmd[nv_pkg::FETCH_PERMIT_BIT] = w[nv_pkg::FETCH_PERMIT_BIT];
          next_s.cmd[nv_pkg::PROG_PERMIT_BIT]  = w[nv_pkg::PROG_PERMIT_BIT];
        end
        if (s.cnt == 8'h01) begin
          next_s.data = mem[s.loc];
          next_s.cmd[nv_pkg::FETCH_START_BIT] = 1'b0;
          next_s.st = nv_pkg::st_idle;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      nv_pkg::st_prog: begin
        if (req.wr && sel_cmd) begin
          next_s.cmd[nv_pkg::FETCH_PERMIT_BIT] = w[nv_pkg::FETCH_PERMIT_BIT];
          next_s.cmd[nv_pkg::PROG_PERMIT_BIT]  = w[nv_pkg::PROG_PERMIT_BIT];
        end
        if (tick_edge) begin
          if (s.cnt == 8'h01) begin
            mem_we = 1'b1;
            next_s.cmd[nv_pkg::PROG_START_BIT] = 1'b0;
            next_s.pend = 1'b1;
            next_s.st = nv_pkg::st_idle;
          end else begin
            next_s.cnt = s.cnt - 8'h01;
          end
        end
      end
      default: begin
        next_s.st = nv_pkg::st_idle;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s       <= '0;
      s.st    <= nv_pkg::st_idle;
      s.cmd   <= nv_pkg::CMD_RESET;
      s.loc   <= ADDR_BITS'(nv_pkg::LOC_RESET);
      s.data  <= nv_pkg::BYTE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // array contents survive reset, as nonvolatile storage should
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[s.loc] <= s.data;
    end
  end

  assign rdata           = s.rdata;
  assign nv_done_pending = s.pend;
  assign prog_busy       = s.cmd[nv_pkg::PROG_START_BIT];

endmodule // nv_byte_access_ctrl

// *** tb/nv_byte_access_ctrl_assertions.sv ***
// checker for the nv byte access controller ports
// assumes bind onto nv_byte_access_ctrl, one clock
`timescale 1ns/1ns
module nv_byte_access_ctrl_assertions #(
  parameter int ADDR_BITS  = 6,
  parameter int PROG_TICKS = 2
) (
  input wire logic             clk_sys,
  input wire logic             nrst,
  input wire nv_pkg::sfr_req_t req,
  input wire logic             prog_tick,
  input wire logic             irq_serviced,
  input wire logic [7:0]       rdata,
  input wire logic             nv_done_pending,
  input wire logic             prog_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire cmd_sel = req.bank == 8'h01 && req.addr == 8'h40;
  property p_cmd_hi; cmd_sel |=> rdata[7:4] == 4'h0; endproperty
  a_cmd_hi: assert property (p_cmd_hi) else $error("cmd upper bits set");
  property p_loc_hi; req.bank == 8'h00 && req.addr == 8'h00 |=> rdata[7:ADDR_BITS] == '0; endproperty
  a_loc_hi: assert property (p_loc_hi) else $error("loc upper bits set");
  property p_unmap; req.bank == 8'h00 && req.addr == 8'h02 |=> rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_start; $rose(prog_busy) |-> $past(req.wr && cmd_sel && req.wdata[2])
    || (req.wr && cmd_sel && req.wdata[2]); endproperty
  a_start: assert property (p_start) else $error("busy without start write");
  property p_len; $rose(prog_busy) |=> prog_busy[*2] ##[1:200] !prog_busy; endproperty
  a_len: assert property (p_len) else $error("program length wrong");
  property p_done; $fell(prog_busy) |-> ##[0:1] nv_done_pending; endproperty
  a_done: assert property (p_done) else $error("no pending after program");
  property p_rise; $rose(nv_done_pending) |-> $past(prog_busy) || $past(prog_busy, 2); endproperty
  a_rise: assert property (p_rise) else $error("pending without program");
  property p_hold; nv_done_pending && !irq_serviced |=> nv_done_pending; endproperty
  a_hold: assert property (p_hold) else $error("pending dropped");
  property p_clear; nv_done_pending && irq_serviced && !prog_busy && !$past(prog_busy)
    |=> !nv_done_pending; endproperty
  a_clear: assert property (p_clear) else $error("pending not cleared");
endmodule // nv_byte_access_ctrl_assertions
bind nv_byte_access_ctrl nv_byte_access_ctrl_assertions #(.ADDR_BITS(ADDR_BITS),
  .PROG_TICKS(PROG_TICKS)) u_sva (.clk_sys(clk_sys), .nrst(nrst), .req(req),
  .prog_tick(prog_tick), .irq_serviced(irq_serviced), .rdata(rdata),
  .nv_done_pending(nv_done_pending), .prog_busy(prog_busy));

// *** tb/nv_tick_source.sv ***
// free-running program timer source
// assumes nothing of the system clock
`timescale 1ns/1ns
module nv_tick_source (
  output logic prog_tick
);
  // period unrelated to clk_sys so completion lands on varying edges
  initial prog_tick = 1'b0;
  always #13 prog_tick = ~prog_tick;
endmodule // nv_tick_source

// *** tb/tb_eeprom_byte_access_ctrl.sv ***
// self-checking bench for the nv byte access controller
// assumes the checker is bound in and the tick source runs free
`timescale 1ns/1ns
module tb_eeprom_byte_access_ctrl;
  logic             clk_sys = 1'b0;
  logic             nrst = 1'b0;
  logic             irq_serviced = 1'b0;
  logic             prog_tick, nv_done_pending, prog_busy, pend = 1'b0;
  nv_pkg::sfr_req_t req = '0;
  logic [7:0]       rdata, a, d, exp_q[$];
  int               err_count = 0, checks = 0;
  always #2 clk_sys = ~clk_sys;
  nv_tick_source tick (.prog_tick(prog_tick));
  nv_byte_access_ctrl #(.ADDR_BITS(6), .PROG_TICKS(2)) uut (.clk_sys(clk_sys), .nrst(nrst),
    .req(req), .prog_tick(prog_tick), .irq_serviced(irq_serviced), .rdata(rdata),
    .nv_done_pending(nv_done_pending), .prog_busy(prog_busy));
  task chk(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task acc(input logic w, input logic r, input logic [7:0] b, input logic [7:0] ad,
           input logic [7:0] dt);
    @(posedge clk_sys);
    #1 req = '{w, r, b, ad, dt};
  endtask
  task wr(input logic [7:0] b, input logic [7:0] ad, input logic [7:0] dt);
    acc(1'b1, 1'b0, b, ad, dt);
  endtask
  task rd(input logic [7:0] b, input logic [7:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, 1'b1, b, ad, 8'h00);
  endtask
  task idle;
    acc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
  endtask
  // read data lands one edge after the read is taken
  always @(posedge clk_sys) begin
    pend <= req.rd;
    if (pend) chk(exp_q.pop_front(), rdata);
  end
  task finish_test;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #40000 err_count++;
    finish_test;
  end
  initial begin
    void'($urandom(96));
    repeat (2) @(posedge clk_sys);
    #1 nrst = 1'b1;
    rd(8'h01, 8'h40, 8'h00);
    rd(8'h00, 8'h01, 8'h00);
    rd(8'h00, 8'h02, 8'h00);
    wr(8'h00, 8'h00, 8'hff);
    rd(8'h00, 8'h00, 8'h3f);
    wr(8'h01, 8'h40, 8'h04);
    wr(8'h01, 8'h40, 8'h01);
    rd(8'h01, 8'h40, 8'h00);
    repeat (3) begin
      a = 8'($urandom_range(63));
      d = 8'($urandom);
      wr(8'h00, 8'h00, a);
      wr(8'h00, 8'h01, d);
      wr(8'h01, 8'h40, 8'h08);
      wr(8'h01, 8'h40, 8'h0c);
      idle;
      for (int k = 0; k < 200 && prog_busy !== 1'b0; k++) #4;
      idle;
      chk(8'h01, {7'h00, nv_done_pending});
      rd(8'h01, 8'h40, 8'h08);
      irq_serviced = 1'b1;
      idle;
      irq_serviced = 1'b0;
      wr(8'h00, 8'h01, ~d);
      wr(8'h01, 8'h40, 8'h02);
      wr(8'h01, 8'h40, 8'h03);
      repeat (3) idle;
      rd(8'h01, 8'h40, 8'h02);
      rd(8'h00, 8'h01, d);
      rd(8'h00, 8'h01, d);
      chk(8'h00, {7'h00, nv_done_pending});
    end
    idle;
    finish_test;
  end
endmodule // tb_eeprom_byte_access_ctrl
